// ---- rtl/drive_consts.svh ----
`ifndef DRIVE_CONSTS_SVH
`define DRIVE_CONSTS_SVH
// ----------------------------------------
// Object indices
// ----------------------------------------
`define IDX_OPMODE 16'h6060
`define IDX_OPMODE_ACT 16'h6061
`define IDX_CONTROL 16'h6040
`define IDX_STATUS 16'h6041
`define IDX_JOG_ACT 16'h301B
`define IDX_JOG_VEL 16'h3029
`define IDX_SPEED_SRC 16'h1B22
`define IDX_SPEED_SET 16'h2108
`define IDX_SCALE 16'h3006
`define IDX_QSTOP 16'h605A
`define SUB_ZERO 8'h00
`define SUB_JOG_ACT 8'h09
`define SUB_JOG_SLOW 8'h04
`define SUB_JOG_FAST 8'h05
`define SUB_LIM_FREE 8'h06
`define SUB_DENOM 8'h07
`define SUB_NUMER 8'h08
// ----------------------------------------
// Values
// ----------------------------------------
`define MODE_JOG 8'hFF
`define MODE_SPEED 8'hFD
`define MODE_NONE 8'h00
`define CW_SHUTDOWN 16'h0006
`define CW_ENABLE 16'h000F
`define CW_ZERO 16'h0000
`define CW_QSTOP_BIT 2
`define CW_HALT_BIT 8
`define CW_RSV_MASK 16'h0070
`define SW_DISABLED 16'h0040
`define SW_READY 16'h0021
`define SW_ENABLED 16'h4637
`define SW_JOG_RUN 16'h0237
`define SW_SPEED_RUN 16'h0637
`define SW_RSV_MASK 16'h1400
`define SRC_NONE 16'h0000
`define SRC_SETPOINT 16'h0002
`define SPEED_MAX 16'sh7530
`define SPEED_MIN (-16'sh7530)
`define JOG_POS_BIT 0
`define JOG_NEG_BIT 1
`define JOG_FAST_BIT 2
`define JOG_SLOW_DEF 16'h003C
`define JOG_FAST_DEF 16'h00B4
`define DENOM_VAL 32'h0000_4000
`define NUMER_VAL 32'h0000_0001
`define QSTOP_VAL 32'h0000_0006
`define LIMFREE_VAL 32'h0000_0000
`define EX_JOG_SLOW 32'h0000_0064
`define EX_JOG_FAST 32'h0000_012C
`define EX_SPEED 32'h0000_0258
`define STEP_SETTLE 16'h0008
`endif

// ---- rtl/drive_pkg.sv ----
package drive_pkg;
  typedef enum logic [1:0] {ACT_IDLE, ACT_JOG, ACT_SPEED} active_t;
  typedef enum logic [3:0] {
    H_IDLE, H_CFG, H_CW0, H_CW6, H_CWF, H_CHK_EN, H_MODE, H_CHK_MODE,
    H_SRC, H_RUN, H_STOP, H_DONE
  } host_state_t;
endpackage : drive_pkg

// ---- rtl/drive_link_if.sv ----
`timescale 1ns/1ps
interface drive_link_if;
  logic wr_valid;
  logic [15:0] wr_index;
  logic [7:0] wr_sub;
  logic [31:0] wr_data;
  logic [15:0] status_word;
  logic [7:0] mode_display;
  modport device (input wr_valid, input wr_index, input wr_sub, input wr_data,
    output status_word, output mode_display);
  modport master (output wr_valid, output wr_index, output wr_sub, output wr_data,
    input status_word, input mode_display);
endinterface : drive_link_if

// ---- rtl/drive_device.sv ----
// Overview of operation
// R1 - Mode code FF selects jog
// R2 - Mode display shows active mode code
// R3 - Master enables stage: 00, 06, 0F
// R4 - Enabled status word reads 4637
// R5 - Jog value 01 starts, 00 stops
// R6 - Slow positive jog status reads 0237
// R7 - Master writes example startup settings
// R8 - Master writes jog velocities first
// R9 - Standstill window only for step moves
// R10 - Speed mode applies no ramp
// R11 - Speed needs mode and source 2
// R12 - Setpoint write starts or updates motion
// R13 - Source accepts 0 or 2, immediate
// R14 - Master keeps control bits 4-6 clear
// R15 - Status bits 10, 12 reserved in speed
// R16 - Speed ends only at standstill after stop; code also switches to jog when mode FF is written
// R17 - Setpoint signed 16-bit, +-30000 rpm
// R18 - Speed clamped to maximum limit
// R19 - Separate current and velocity limits
// R20 - Jog bits: pos, neg, fast; both none
// R21 - Unsupported source values are ignored
`timescale 1ns/1ps
`include "drive_consts.svh"
module drive_device #(
  parameter logic signed [15:0] MAX_SPEED = `SPEED_MAX,
  parameter logic [15:0] MAX_CURRENT = 16'h0FFF
) (
  input wire logic clk,
  input wire logic rst_n,
  drive_link_if.device link,
  input wire logic fault,
  input wire logic step_move,
  input wire logic [15:0] current_request,
  output logic signed [15:0] velocity_cmd,
  output logic [15:0] current_limit,
  output logic stage_enabled,
  output logic standstill_check
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] mode_sel;
    logic [7:0] mode_act;
    logic [15:0] control;
    logic [1:0] en_seq;
    logic enabled;
    logic [2:0] jog_act;
    logic [15:0] jog_slow;
    logic [15:0] jog_fast;
    logic [15:0] speed_src;
    logic signed [15:0] setpoint;
    logic speed_go;
    logic stopping;
    logic signed [15:0] vel;
    logic [15:0] cur_lim;
    logic [15:0] status;
  } dev_state_t;
  dev_state_t r;
  dev_state_t next_r;
  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  logic wr_ctl;
  logic wr_mode;
  logic wr_jog;
  logic wr_vel;
  logic wr_src;
  logic wr_set;
  logic signed [15:0] target;
  logic jog_pos;
  logic jog_neg;
  logic stop_req;
  always_comb begin
    next_r = r;
    target = 16'sh0000;
    wr_ctl = link.wr_valid && link.wr_index == `IDX_CONTROL;
    wr_mode = link.wr_valid && link.wr_index == `IDX_OPMODE;
    wr_jog = link.wr_valid && link.wr_index == `IDX_JOG_ACT && link.wr_sub == `SUB_JOG_ACT;
    wr_vel = link.wr_valid && link.wr_index == `IDX_JOG_VEL;
    wr_src = link.wr_valid && link.wr_index == `IDX_SPEED_SRC;
    wr_set = link.wr_valid && link.wr_index == `IDX_SPEED_SET;
    jog_pos = r.jog_act[`JOG_POS_BIT] && !r.jog_act[`JOG_NEG_BIT]; // R20
    jog_neg = r.jog_act[`JOG_NEG_BIT] && !r.jog_act[`JOG_POS_BIT]; // R20
    stop_req = fault || !r.control[`CW_QSTOP_BIT] || r.control[`CW_HALT_BIT];
    // ----------------------------------------
    // Object writes
    // ----------------------------------------
    if (wr_ctl) begin
      next_r.control = link.wr_data[15:0];
      if (link.wr_data[15:0] == `CW_ZERO) begin
        next_r.en_seq = 2'h0;
        next_r.enabled = 1'b0;
      end else if (link.wr_data[15:0] == `CW_SHUTDOWN) begin
        next_r.en_seq = 2'h1;
      end else if (link.wr_data[15:0] == `CW_ENABLE && r.en_seq != 2'h0) begin
        next_r.en_seq = 2'h2;
        next_r.enabled = 1'b1;
      end
    end
    if (wr_mode) begin
      next_r.mode_sel = link.wr_data[7:0]; // R1
      next_r.speed_go = 1'b0;
    end
    if (wr_jog) begin
      next_r.jog_act = link.wr_data[2:0]; // R5
    end
    if (wr_vel) begin
      if (link.wr_sub == `SUB_JOG_SLOW) begin
        next_r.jog_slow = link.wr_data[15:0];
      end
      if (link.wr_sub == `SUB_JOG_FAST) begin
        next_r.jog_fast = link.wr_data[15:0];
      end
    end
    if (wr_src) begin
      if (link.wr_data[15:0] == `SRC_NONE || link.wr_data[15:0] == `SRC_SETPOINT) begin
        next_r.speed_src = link.wr_data[15:0]; // R13 R21
      end
    end
    if (wr_set) begin
      if ($signed(link.wr_data[15:0]) > `SPEED_MAX) begin
        next_r.setpoint = `SPEED_MAX; // R17
      end else if ($signed(link.wr_data[15:0]) < `SPEED_MIN) begin
        next_r.setpoint = `SPEED_MIN; // R17
      end else begin
        next_r.setpoint = link.wr_data[15:0];
      end
      next_r.speed_go = 1'b1; // R12
    end
    // ----------------------------------------
    // Mode activation and termination
    // ----------------------------------------
    if (!r.enabled || stop_req) begin
      next_r.stopping = r.mode_act != `MODE_NONE;
    end else begin
      next_r.stopping = 1'b0;
    end
    if (r.stopping && r.vel == 16'sh0000) begin
      next_r.mode_act = `MODE_NONE; // R16
      next_r.speed_go = 1'b0;
      if (!wr_mode) begin
        next_r.mode_sel = `MODE_NONE; // R16
      end
    end else if (!r.stopping && r.enabled && !stop_req) begin
      if (r.mode_sel == `MODE_JOG) begin
        next_r.mode_act = `MODE_JOG; // R1 R2
      end else if (r.mode_sel == `MODE_SPEED && r.speed_src == `SRC_SETPOINT) begin
        next_r.mode_act = `MODE_SPEED; // R11
      end
    end
    // ----------------------------------------
    // Velocity command
    // ----------------------------------------
    if (!r.stopping && r.mode_act == `MODE_JOG && (jog_pos || jog_neg)) begin
      target = r.jog_act[`JOG_FAST_BIT] ? $signed(r.jog_fast) : $signed(r.jog_slow); // R20
      if (jog_neg) begin
        target = -target;
      end
    end else if (!r.stopping && r.mode_act == `MODE_SPEED && r.speed_go
        && r.speed_src == `SRC_SETPOINT) begin
      target = r.setpoint; // R10 R12
    end
    // ----------------------------------------
    // Speed limit
    // ----------------------------------------
    if (target > MAX_SPEED) begin
      target = MAX_SPEED; // R18 R19
    end else if (target < -MAX_SPEED) begin
      target = -MAX_SPEED; // R18 R19
    end
    next_r.vel = target; // R10
    next_r.cur_lim = current_request > MAX_CURRENT ? MAX_CURRENT : current_request; // R19
    // ----------------------------------------
    // Status word
    // ----------------------------------------
    if (!r.enabled) begin
      next_r.status = r.en_seq == 2'h1 ? `SW_READY : `SW_DISABLED;
    end else if (r.mode_act == `MODE_JOG && r.vel != 16'sh0000) begin
      next_r.status = `SW_JOG_RUN; // R6
    end else if (r.mode_act == `MODE_SPEED && r.vel != 16'sh0000) begin
      next_r.status = `SW_SPEED_RUN & ~`SW_RSV_MASK; // R15
    end else begin
      next_r.status = `SW_ENABLED; // R4
    end
  end
  // ----------------------------------------
  // Register update
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.jog_slow <= `JOG_SLOW_DEF;
      r.jog_fast <= `JOG_FAST_DEF;
      r.status <= `SW_DISABLED;
    end else begin
      r <= next_r;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.status_word = r.status;
  assign link.mode_display = r.mode_act; // R2
  assign velocity_cmd = r.vel;
  assign current_limit = r.cur_lim;
  assign stage_enabled = r.enabled;
  assign standstill_check = r.mode_act == `MODE_JOG && step_move; // R9
endmodule : drive_device

// ---- rtl/drive_master.sv ----
`timescale 1ns/1ps
`include "drive_consts.svh"
module drive_master (
  input wire logic clk,
  input wire logic rst_n,
  drive_link_if.master link,
  input wire logic start,
  input wire logic use_speed,
  input wire logic stop,
  output logic busy,
  output logic running,
  output logic error
);
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef struct packed {
    drive_pkg::host_state_t st;
    logic [2:0] cfg;
    logic [15:0] wait_cnt;
    logic wv;
    logic [15:0] idx;
    logic [7:0] sub;
    logic [31:0] data;
    logic spd;
    logic err;
  } host_t;
  host_t r;
  host_t next_r;
  always_comb begin
    next_r = r;
    next_r.wv = 1'b0;
    next_r.wait_cnt = r.wait_cnt + 16'h0001;
    case (r.st)
      drive_pkg::H_IDLE: begin
        if (start) begin
          next_r.st = drive_pkg::H_CFG;
          next_r.cfg = 3'h0;
          next_r.spd = use_speed;
          next_r.err = 1'b0;
        end
      end
      drive_pkg::H_CFG: begin
        next_r.wv = 1'b1;
        next_r.cfg = r.cfg + 3'h1;
        case (r.cfg)
          3'h0: {next_r.idx, next_r.sub, next_r.data} = {`IDX_SCALE, `SUB_DENOM, `DENOM_VAL}; // R7
          3'h1: {next_r.idx, next_r.sub, next_r.data} = {`IDX_SCALE, `SUB_NUMER, `NUMER_VAL}; // R7
          3'h2: {next_r.idx, next_r.sub, next_r.data} = {`IDX_QSTOP, `SUB_ZERO, `QSTOP_VAL}; // R7
          3'h3: {next_r.idx, next_r.sub, next_r.data} = {`IDX_SCALE, `SUB_LIM_FREE, `LIMFREE_VAL}; // R7
          3'h4: {next_r.idx, next_r.sub, next_r.data} = {`IDX_JOG_VEL, `SUB_JOG_SLOW, `EX_JOG_SLOW}; // R8
          default: begin
            {next_r.idx, next_r.sub, next_r.data} = {`IDX_JOG_VEL, `SUB_JOG_FAST, `EX_JOG_FAST}; // R8
            next_r.st = drive_pkg::H_CW0;
          end
        endcase
      end
      drive_pkg::H_CW0: begin
        next_r.wv = 1'b1;
        {next_r.idx, next_r.sub, next_r.data} = {`IDX_CONTROL, `SUB_ZERO, 32'h0000_0000}; // R3
        next_r.st = drive_pkg::H_CW6;
      end
      drive_pkg::H_CW6: begin
        next_r.wv = 1'b1;
        {next_r.idx, next_r.sub, next_r.data} = {`IDX_CONTROL, `SUB_ZERO, 32'h0000_0006}; // R3
        next_r.st = drive_pkg::H_CWF;
      end
      drive_pkg::H_CWF: begin
        next_r.wv = 1'b1;
        {next_r.idx, next_r.sub, next_r.data} = {`IDX_CONTROL, `SUB_ZERO, 32'h0000_000F}; // R3 R14
        next_r.st = drive_pkg::H_CHK_EN;
        next_r.wait_cnt = 16'h0000;
      end
      drive_pkg::H_CHK_EN: begin
        if (link.status_word == `SW_ENABLED) begin
          next_r.st = r.spd ? drive_pkg::H_SRC : drive_pkg::H_MODE; // R4
        end else if (r.wait_cnt == `STEP_SETTLE) begin
          next_r.err = 1'b1;
          next_r.st = drive_pkg::H_IDLE;
        end
      end
      drive_pkg::H_SRC: begin
        next_r.wv = 1'b1;
        {next_r.idx, next_r.sub, next_r.data} = {`IDX_SPEED_SRC, `SUB_ZERO, 32'h0000_0002}; // R11
        next_r.st = drive_pkg::H_MODE;
      end
      drive_pkg::H_MODE: begin
        next_r.wv = 1'b1;
        next_r.idx = `IDX_OPMODE;
        next_r.sub = `SUB_ZERO;
        next_r.data = {24'h00_0000, r.spd ? `MODE_SPEED : `MODE_JOG}; // R1 R11
        next_r.st = drive_pkg::H_CHK_MODE;
        next_r.wait_cnt = 16'h0000;
      end
      drive_pkg::H_CHK_MODE: begin
        if (link.mode_display == (r.spd ? `MODE_SPEED : `MODE_JOG)) begin
          next_r.st = drive_pkg::H_RUN;
        end else if (r.wait_cnt == `STEP_SETTLE) begin
          next_r.err = 1'b1;
          next_r.st = drive_pkg::H_IDLE;
        end
      end
      drive_pkg::H_RUN: begin
        next_r.wv = 1'b1;
        if (r.spd) begin
          {next_r.idx, next_r.sub, next_r.data} = {`IDX_SPEED_SET, `SUB_ZERO, `EX_SPEED};
        end else begin
          {next_r.idx, next_r.sub, next_r.data} = {`IDX_JOG_ACT, `SUB_JOG_ACT, 32'h0000_0001}; // R5
        end
        next_r.st = drive_pkg::H_STOP;
      end
      drive_pkg::H_STOP: begin
        if (stop) begin
          next_r.wv = 1'b1;
          if (r.spd) begin
            {next_r.idx, next_r.sub, next_r.data} = {`IDX_CONTROL, `SUB_ZERO, 32'h0000_000B};
          end else begin
            {next_r.idx, next_r.sub, next_r.data} = {`IDX_JOG_ACT, `SUB_JOG_ACT, 32'h0000_0000}; // R5
          end
          next_r.st = drive_pkg::H_DONE;
        end
      end
      drive_pkg::H_DONE: begin
        next_r.st = drive_pkg::H_IDLE;
      end
      default: begin
        next_r.st = drive_pkg::H_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign link.wr_valid = r.wv;
  assign link.wr_index = r.idx;
  assign link.wr_sub = r.sub;
  assign link.wr_data = r.data;
  assign busy = r.st != drive_pkg::H_IDLE;
  assign running = r.st == drive_pkg::H_STOP;
  assign error = r.err;
endmodule : drive_master

// ---- test/drive_jog_and_speed_modes_props.sv ----
`timescale 1ns/1ps
`include "drive_consts.svh"
module drive_jog_and_speed_modes_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_valid,
  input wire logic [15:0] wr_index,
  input wire logic [7:0] wr_sub,
  input wire logic [31:0] wr_data,
  input wire logic [15:0] status_word,
  input wire logic [7:0] mode_display
);
  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  logic vel_seen;
  logic src_seen;
  wire [15:0] data_w = wr_data[15:0];
  wire [7:0] data_lo = wr_data[7:0];
  wire wr_ctl = wr_valid && (wr_index == `IDX_CONTROL);
  wire wr_mode = wr_valid && (wr_index == `IDX_OPMODE);
  wire wr_jog = wr_valid && (wr_index == `IDX_JOG_ACT) && (wr_sub == `SUB_JOG_ACT);
  wire wr_set = wr_valid && (wr_index == `IDX_SPEED_SET);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vel_seen <= 1'b0;
      src_seen <= 1'b0;
    end else begin
      if (wr_valid && wr_index == `IDX_JOG_VEL) begin
        vel_seen <= 1'b1;
      end
      if (wr_valid && wr_index == `IDX_SPEED_SRC && data_w == `SRC_SETPOINT) begin
        src_seen <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence enable_seq;
    wr_ctl && data_w == `CW_ZERO ##1 wr_ctl && data_w == `CW_SHUTDOWN
      ##1 wr_ctl && data_w == `CW_ENABLE;
  endsequence
  chk_enable_status: assert property (enable_seq |-> ##2 status_word == `SW_ENABLED)
    else $error("status not enabled after enable writes");
  chk_enable_order: assert property (wr_ctl && data_w == `CW_ENABLE |->
    $past(wr_ctl) && $past(data_w) == `CW_SHUTDOWN)
    else $error("enable write not preceded by shutdown write");
  chk_jog_mode_shown: assert property (wr_mode && data_lo == `MODE_JOG &&
    status_word == `SW_ENABLED |-> ##2 mode_display == `MODE_JOG)
    else $error("jog mode not shown");
  chk_mode_cause: assert property ($changed(mode_display) && mode_display != `MODE_NONE |->
    $past(wr_mode, 2) && $past(data_lo, 2) == mode_display)
    else $error("mode display changed without mode write");
  chk_jog_run_status: assert property (wr_jog && data_w == 16'h0001 &&
    mode_display == `MODE_JOG |-> ##3 status_word == `SW_JOG_RUN)
    else $error("jog run status wrong");
  chk_jog_end_status: assert property (wr_jog && data_w == 16'h0000 &&
    mode_display == `MODE_JOG |-> ##[1:4] status_word == `SW_ENABLED)
    else $error("jog did not end");
  chk_speed_run: assert property (wr_set && mode_display == `MODE_SPEED && src_seen &&
    data_w != 16'h0000 |-> ##[1:3] status_word == (`SW_SPEED_RUN & ~`SW_RSV_MASK))
    else $error("setpoint write did not start motion");
  chk_speed_source: assert property (wr_mode && data_lo == `MODE_SPEED |-> src_seen)
    else $error("speed mode selected before source set");
  chk_jog_vel_first: assert property (wr_jog && data_w == 16'h0001 |-> vel_seen)
    else $error("jog started before velocities written");
  chk_ctl_reserved: assert property (wr_ctl && mode_display == `MODE_SPEED |->
    (data_w & `CW_RSV_MASK) == 16'h0000)
    else $error("reserved control bits set in speed mode");
  cover property (enable_seq);
  cover property (status_word == `SW_JOG_RUN);
  cover property (status_word == (`SW_SPEED_RUN & ~`SW_RSV_MASK));
endmodule : drive_jog_and_speed_modes_props

// ---- test/test_drive_jog_and_speed_modes.sv ----
`timescale 1ns/1ps
`include "drive_consts.svh"
module test_drive_jog_and_speed_modes;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic use_speed = 1'b0;
  logic stop = 1'b0;
  logic fault = 1'b0;
  logic step_move = 1'b0;
  logic [15:0] current_request = 16'h0000;
  logic busy, running, error, stage_enabled, stage_enabled_b, standstill_check;
  logic signed [15:0] velocity_cmd;
  logic signed [15:0] velocity_b;
  logic signed [15:0] velocity_c;
  logic [15:0] current_limit;
  int failures = 0;
  int n_checks = 0;
  drive_link_if link ();
  drive_link_if link_b ();
  drive_link_if link_c ();
  always #5 clk = ~clk;
  drive_master i_drive_master (.clk(clk), .rst_n(rst_n), .link(link), .start(start),
    .use_speed(use_speed), .stop(stop), .busy(busy), .running(running), .error(error));
  drive_device i_drive_device (.clk(clk), .rst_n(rst_n), .link(link), .fault(fault),
    .step_move(step_move), .current_request(current_request), .velocity_cmd(velocity_cmd),
    .current_limit(current_limit), .stage_enabled(stage_enabled),
    .standstill_check(standstill_check));
  drive_device #(.MAX_SPEED(16'sh4E20)) i_drive_device_b (.clk(clk), .rst_n(rst_n),
    .link(link_b), .fault(fault), .step_move(1'b0), .current_request(16'h0000),
    .velocity_cmd(velocity_b), .current_limit(), .stage_enabled(stage_enabled_b),
    .standstill_check());
  drive_device #(.MAX_SPEED(16'sh7FFF)) i_drive_device_c (.clk(clk), .rst_n(rst_n),
    .link(link_c), .fault(fault), .step_move(1'b0), .current_request(16'h0000),
    .velocity_cmd(velocity_c), .current_limit(), .stage_enabled(),
    .standstill_check());
  drive_jog_and_speed_modes_props i_drive_jog_and_speed_modes_props (.clk(clk),
    .rst_n(rst_n), .wr_valid(link.wr_valid), .wr_index(link.wr_index),
    .wr_sub(link.wr_sub), .wr_data(link.wr_data), .status_word(link.status_word),
    .mode_display(link.mode_display));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles
  task automatic wr_b(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] data);
    link_b.wr_valid = 1'b1;
    link_b.wr_index = idx;
    link_b.wr_sub = sub;
    link_b.wr_data = data;
    link_c.wr_valid = 1'b1;
    link_c.wr_index = idx;
    link_c.wr_sub = sub;
    link_c.wr_data = data;
    @(negedge clk);
    link_b.wr_valid = 1'b0;
    link_c.wr_valid = 1'b0;
    @(negedge clk);
  endtask : wr_b
  task automatic run_master(input logic speed);
    use_speed = speed;
    start = 1'b1;
    cycles(1);
    start = 1'b0;
    for (int i = 0; i < 300 && running !== 1'b1; i++) cycles(1);
    check("running", {15'h0000, running}, 16'h0001);
    check("error", {15'h0000, error}, 16'h0000);
    cycles(5);
  endtask : run_master
  task automatic stop_master();
    stop = 1'b1;
    for (int i = 0; i < 50 && busy !== 1'b0; i++) cycles(1);
    stop = 1'b0;
    cycles(4);
    check("busy", {15'h0000, busy}, 16'h0000);
  endtask : stop_master
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_jog();
    step_move = 1'b1;
    run_master(1'b0);
    check("jog mode", {8'h00, link.mode_display}, {8'h00, `MODE_JOG});
    check("jog status", link.status_word, `SW_JOG_RUN);
    check("jog velocity", velocity_cmd, 16'(`EX_JOG_SLOW));
    check("step window", {15'h0000, standstill_check}, 16'h0001);
    step_move = 1'b0;
    cycles(1);
    check("jog window", {15'h0000, standstill_check}, 16'h0000);
    stop_master();
    check("jog stop velocity", velocity_cmd, 16'h0000);
    check("jog stop status", link.status_word, `SW_ENABLED);
  endtask : t_jog
  task automatic t_speed();
    step_move = 1'b1;
    current_request = 16'hFFFF;
    run_master(1'b1);
    check("speed mode", {8'h00, link.mode_display}, {8'h00, `MODE_SPEED});
    check("speed velocity", velocity_cmd, 16'(`EX_SPEED));
    check("speed status", link.status_word, `SW_SPEED_RUN & ~`SW_RSV_MASK);
    check("speed reserved", link.status_word & `SW_RSV_MASK, 16'h0000);
    check("speed window", {15'h0000, standstill_check}, 16'h0000);
    check("current clamp", current_limit, 16'h0FFF);
    current_request = 16'h0100;
    cycles(2);
    check("current pass", current_limit, 16'h0100);
    step_move = 1'b0;
    stop_master();
    check("speed stop velocity", velocity_cmd, 16'h0000);
  endtask : t_speed
  task automatic t_device_b();
    wr_b(`IDX_CONTROL, `SUB_ZERO, 32'h0000_000F);
    cycles(3);
    check("enable skipped", {15'h0000, stage_enabled_b}, 16'h0000);
    wr_b(`IDX_CONTROL, `SUB_ZERO, 32'h0000_0000);
    wr_b(`IDX_CONTROL, `SUB_ZERO, 32'h0000_0006);
    wr_b(`IDX_CONTROL, `SUB_ZERO, 32'h0000_000F);
    cycles(3);
    check("enabled", link_b.status_word, `SW_ENABLED);
    wr_b(`IDX_SPEED_SRC, `SUB_ZERO, 32'h0000_0002);
    wr_b(`IDX_OPMODE, `SUB_ZERO, 32'h0000_00FD);
    wr_b(`IDX_SPEED_SET, `SUB_ZERO, 32'h0000_0064);
    cycles(2);
    check("setpoint", velocity_b, 16'h0064);
    wr_b(`IDX_SPEED_SRC, `SUB_ZERO, 32'h0000_0001);
    wr_b(`IDX_SPEED_SET, `SUB_ZERO, 32'h0000_00C8);
    cycles(2);
    check("bad source", velocity_b, 16'h00C8);
    wr_b(`IDX_SPEED_SET, `SUB_ZERO, 32'h0000_7FFF);
    cycles(2);
    check("clamp high", velocity_b, 16'h4E20);
    check("limit high", velocity_c, `SPEED_MAX);
    wr_b(`IDX_SPEED_SET, `SUB_ZERO, 32'h0000_8000);
    cycles(2);
    check("clamp low", velocity_b, 16'hB1E0);
    check("limit low", velocity_c, `SPEED_MIN);
    wr_b(`IDX_SPEED_SET, `SUB_ZERO, 32'h0000_0000);
    cycles(2);
    wr_b(`IDX_OPMODE, `SUB_ZERO, 32'h0000_00FF);
    cycles(3);
    check("jog select", {8'h00, link_b.mode_display}, {8'h00, `MODE_JOG});
    wr_b(`IDX_JOG_ACT, `SUB_JOG_ACT, 32'h0000_0003);
    cycles(3);
    check("both dirs", velocity_b, 16'h0000);
    wr_b(`IDX_JOG_ACT, `SUB_JOG_ACT, 32'h0000_0000);
    wr_b(`IDX_JOG_ACT, `SUB_JOG_ACT, 32'h0000_0005);
    cycles(3);
    check("fast jog", velocity_b, `JOG_FAST_DEF);
    wr_b(`IDX_JOG_ACT, `SUB_JOG_ACT, 32'h0000_0000);
  endtask : t_device_b
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    link_b.wr_valid = 1'b0;
    link_b.wr_index = 16'h0000;
    link_b.wr_sub = 8'h00;
    link_b.wr_data = 32'h0000_0000;
    link_c.wr_valid = 1'b0;
    cycles(8);
    rst_n = 1'b1;
    cycles(1);
    t_jog();
    t_speed();
    t_device_b();
    test_done();
  end
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule : test_drive_jog_and_speed_modes
